// ==== verilog/awgsel_defs.svh ====
// constants for the sequencer control and event logger block
//
// Operation
// - clear write empties the logger; old entries read back as zero
// - logger runs only while enabled
// - input select: 0 parallel port, 1 link
// - normal mode starts with sequencer, wraps
// - timed mode waits trigger, then start time
// - timed mode stops at 1024, never overwrites
// - writable start time for timed mode
// - state codes 0 to 4 reported
// - timestamp steps once per 25 ns clock cycle, 4 ns reported read-only
// - program size fraction of 32768 instructions
// - program counter shows current instruction
// - status bits run, trig wait, error, sync
// - trigger-seen flag reads one
// - one-shot setting runs program once
// - rate divider n from 0 to 13
// - user registers shared by software and sequencer
// - wave memory usage percent of 98304
// - playing flag while waveform plays
// - busy flag while applying settings
// - no-upconverter flag per channel
// - marker source mux codes 0 to 17
`ifndef AWGSEL_DEFS_SVH
`define AWGSEL_DEFS_SVH
`define AWGSEL_A_CLEAR 8'h00
`define AWGSEL_A_ENABLE 8'h04
`define AWGSEL_A_INSEL 8'h08
`define AWGSEL_A_MODE 8'h0C
`define AWGSEL_A_START 8'h10
`define AWGSEL_A_STATE 8'h14
`define AWGSEL_A_TBASE 8'h18
`define AWGSEL_A_COUNT 8'h1C
`define AWGSEL_A_RDIDX 8'h20
`define AWGSEL_A_RDVAL 8'h24
`define AWGSEL_A_RDTS 8'h28
`define AWGSEL_A_PSIZE 8'h2C
`define AWGSEL_A_PC 8'h30
`define AWGSEL_A_SFLAGS 8'h34
`define AWGSEL_A_TRIGD 8'h38
`define AWGSEL_A_SINGLE 8'h3C
`define AWGSEL_A_RATE 8'h40
`define AWGSEL_A_WMEM 8'h44
`define AWGSEL_A_PLAY 8'h48
`define AWGSEL_A_BUSY 8'h4C
`define AWGSEL_A_INTERNAL 8'h50
`define AWGSEL_A_MARKER 8'h54
`define AWGSEL_A_USER0 8'h60
`define AWGSEL_NUSER 4
`define AWGSEL_DEPTH 1024
`define AWGSEL_AW 10
`define AWGSEL_STEP_NS 4
`define AWGSEL_CLK_NS 25
`define AWGSEL_IMEM 32768
`define AWGSEL_WMEM 98304
`define AWGSEL_RATE_MAX 4'd13
`define AWGSEL_MK_LOW 5'd16
`define AWGSEL_MK_HIGH 5'd17
`define AWGSEL_ST_RUN 0
`define AWGSEL_ST_TWAIT 2
`define AWGSEL_ST_ERR 3
`define AWGSEL_ST_SYNC 4
`endif

// ==== verilog/awgsel_pkg.sv ====
// types for the sequencer control and event logger block
package awgsel_pkg;
    typedef enum logic [4:0] {
        AWGSEL_IDLE = 5'b0_0001,
        AWGSEL_NORMAL = 5'b0_0010,
        AWGSEL_WAIT = 5'b0_0100,
        AWGSEL_REC = 5'b0_1000,
        AWGSEL_FULL = 5'b1_0000
    } awgsel_state_e;
endpackage

// ==== verilog/awgsel_mem.sv ====
// logger entry memory with registered read data
`timescale 1ns/10ps
module awgsel_mem (
    // clock
    input wire logic clk_i,
    // write side
    input wire logic we_i,
    input wire logic [9:0] waddr_i,
    input wire logic [63:0] wdata_i,
    // read side
    input wire logic [9:0] raddr_i,
    output logic [63:0] rdata_o
);
    logic [63:0] mem_q [0:1023];
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end
    always_ff @(posedge clk_i) begin
        rdata_o <= mem_q[raddr_i];
    end
endmodule

// ==== verilog/awgsel_top.sv ====
// sequencer control, status and real-time event logger
`timescale 1ns/10ps
`include "awgsel_defs.svh"
module awgsel_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // event sources
    input wire logic [31:0] dio_data_i,
    input wire logic dio_valid_i,
    input wire logic [31:0] link_data_i,
    input wire logic link_valid_i,
    // sequencer status inputs
    input wire logic seq_running_i,
    input wire logic seq_wait_trig_i,
    input wire logic seq_error_i,
    input wire logic seq_wait_sync_i,
    input wire logic seq_trigger_i,
    input wire logic [14:0] program_counter_i,
    input wire logic [15:0] prog_len_i,
    input wire logic [16:0] wave_len_i,
    input wire logic wave_playing_i,
    input wire logic settling_i,
    input wire logic no_upconv_i,
    // sequencer user register port
    input wire logic seq_ureg_we_i,
    input wire logic [1:0] seq_ureg_idx_i,
    input wire logic [31:0] seq_ureg_wdata_i,
    output logic [31:0] seq_ureg_rdata_o,
    // marker sources
    input wire logic [3:0] sequencer_trigger_line_i,
    input wire logic [3:0] waveform_marker_bit_i,
    input wire logic [7:0] trigger_input_line_i,
    // settings out
    output logic one_shot_o,
    output logic [3:0] rate_div_o,
    output logic marker_o
);
    localparam int STEP_CYC = (`AWGSEL_STEP_NS + `AWGSEL_CLK_NS - 1)
                              / `AWGSEL_CLK_NS;
    logic [31:0] start_time_q;
    logic enable_q, insel_q, mode_q;
    logic [31:0] ts_q;
    logic [10:0] count_q;
    logic [9:0] wptr_q, rdidx_q;
    logic trig_seen_q, run_d1_q;
    logic [31:0] ureg_q [0:`AWGSEL_NUSER-1];
    logic [4:0] mk_sel_q;
    logic one_shot_q;
    logic [3:0] rate_q;
    logic [63:0] rd_word;
    logic wait_q;
    awgsel_pkg::awgsel_state_e state_q;
    logic ev_valid;
    logic [31:0] ev_data;
    logic wr_en;
    logic clr;
    logic bus_wr;
    logic [2:0] st_code;
    // reads and writes both take one wait cycle; writes commit while waitrequest is low
    assign bus_wr = avs_write_i & ~avs_waitrequest_o;
    assign clr = bus_wr && avs_address_i == `AWGSEL_A_CLEAR;
    assign ev_valid = insel_q ? link_valid_i : dio_valid_i;
    assign ev_data = insel_q ? link_data_i : dio_data_i;
    assign wr_en = ev_valid && (state_q == awgsel_pkg::AWGSEL_NORMAL ||
                   state_q == awgsel_pkg::AWGSEL_REC);
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
            wait_q <= 1'b0;
        end else begin
            wait_q <= (avs_read_i | avs_write_i) & ~wait_q
                      & avs_waitrequest_o;
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~wait_q
                                   & avs_waitrequest_o);
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            enable_q <= 1'b0;
            insel_q <= 1'b0;
            mode_q <= 1'b0;
            start_time_q <= 32'h0000_0000;
            rdidx_q <= 10'h000;
            one_shot_q <= 1'b0;
            rate_q <= 4'h0;
            mk_sel_q <= 5'h00;
        end else if (bus_wr) begin
            case (avs_address_i)
                `AWGSEL_A_ENABLE: enable_q <= avs_writedata_i[0];
                `AWGSEL_A_INSEL: insel_q <= avs_writedata_i[0];
                `AWGSEL_A_MODE: mode_q <= avs_writedata_i[0];
                `AWGSEL_A_START: start_time_q <= avs_writedata_i;
                `AWGSEL_A_RDIDX: rdidx_q <= avs_writedata_i[9:0];
                `AWGSEL_A_SINGLE: one_shot_q <= avs_writedata_i[0];
                `AWGSEL_A_RATE: begin
                    // out-of-range values clamp to the slowest rate
                    if (avs_writedata_i[3:0] > `AWGSEL_RATE_MAX) begin
                        rate_q <= `AWGSEL_RATE_MAX;
                    end else begin
                        rate_q <= avs_writedata_i[3:0];
                    end
                end
                `AWGSEL_A_MARKER: begin
                    if (avs_writedata_i[4:0] <= `AWGSEL_MK_HIGH) begin
                        mk_sel_q <= avs_writedata_i[4:0];
                    end
                end
                default: ;
            endcase
        end
    end
    // user registers: sequencer write wins a same-cycle collision
    genvar gi;
    generate
        for (gi = 0; gi < `AWGSEL_NUSER; gi++) begin : g_ureg
            always_ff @(posedge clk_i) begin
                if (!rst_b_i) begin
                    ureg_q[gi] <= 32'h0000_0000;
                end else if (seq_ureg_we_i && seq_ureg_idx_i == gi) begin
                    ureg_q[gi] <= seq_ureg_wdata_i;
                end else if (bus_wr && avs_address_i ==
                             8'(`AWGSEL_A_USER0 + 4 * gi)) begin
                    ureg_q[gi] <= avs_writedata_i;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            seq_ureg_rdata_o <= 32'h0000_0000;
        end else begin
            seq_ureg_rdata_o <= ureg_q[seq_ureg_idx_i];
        end
    end
    // timestamp in sequencer steps since sequencer start
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ts_q <= 32'h0000_0000;
            run_d1_q <= 1'b0;
        end else begin
            run_d1_q <= seq_running_i;
            if (seq_running_i && !run_d1_q) begin
                ts_q <= 32'h0000_0000;
            end else if (seq_running_i) begin
                ts_q <= ts_q + 32'(STEP_CYC);
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            trig_seen_q <= 1'b0;
        end else if (seq_trigger_i) begin
            trig_seen_q <= 1'b1;
        end else if (seq_running_i && !run_d1_q) begin
            trig_seen_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !enable_q) begin
            state_q <= awgsel_pkg::AWGSEL_IDLE;
        end else begin
            case (state_q)
                awgsel_pkg::AWGSEL_IDLE: begin
                    if (seq_running_i) begin
                        state_q <= mode_q ? awgsel_pkg::AWGSEL_WAIT
                                          : awgsel_pkg::AWGSEL_NORMAL;
                    end
                end
                awgsel_pkg::AWGSEL_NORMAL: begin
                    if (!seq_running_i) begin
                        state_q <= awgsel_pkg::AWGSEL_IDLE;
                    end
                end
                awgsel_pkg::AWGSEL_WAIT: begin
                    if (!seq_running_i) begin
                        state_q <= awgsel_pkg::AWGSEL_IDLE;
                    end else if (trig_seen_q && ts_q >= start_time_q) begin
                        state_q <= awgsel_pkg::AWGSEL_REC;
                    end
                end
                awgsel_pkg::AWGSEL_REC: begin
                    if (count_q == 11'(`AWGSEL_DEPTH) ||
                        (wr_en && count_q == 11'(`AWGSEL_DEPTH - 1))) begin
                        state_q <= awgsel_pkg::AWGSEL_FULL;
                    end else if (!seq_running_i) begin
                        state_q <= awgsel_pkg::AWGSEL_IDLE;
                    end
                end
                awgsel_pkg::AWGSEL_FULL: begin
                    if (clr) begin
                        state_q <= awgsel_pkg::AWGSEL_IDLE;
                    end
                end
                default: state_q <= awgsel_pkg::AWGSEL_IDLE;
            endcase
        end
    end
    // clear resets pointer and count; stale words become unreadable
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || clr) begin
            wptr_q <= 10'h000;
            count_q <= 11'h000;
        end else if (wr_en) begin
            wptr_q <= wptr_q + 10'h001;
            if (count_q != 11'(`AWGSEL_DEPTH)) begin
                count_q <= count_q + 11'h001;
            end
        end
    end
    awgsel_mem u_mem (
        .clk_i(clk_i),
        .we_i(wr_en),
        .waddr_i(wptr_q),
        .wdata_i({ts_q, ev_data}),
        .raddr_i(rdidx_q),
        .rdata_o(rd_word)
    );
    always_comb begin
        case (state_q)
            awgsel_pkg::AWGSEL_NORMAL: st_code = 3'd1;
            awgsel_pkg::AWGSEL_WAIT: st_code = 3'd2;
            awgsel_pkg::AWGSEL_REC: st_code = 3'd3;
            awgsel_pkg::AWGSEL_FULL: st_code = 3'd4;
            default: st_code = 3'd0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o && !wait_q) begin
            // data registered as waitrequest drops, so it stands when taken
            case (avs_address_i)
                `AWGSEL_A_ENABLE: avs_readdata_o <= {31'h0, enable_q};
                `AWGSEL_A_INSEL: avs_readdata_o <= {31'h0, insel_q};
                `AWGSEL_A_MODE: avs_readdata_o <= {31'h0, mode_q};
                `AWGSEL_A_START: avs_readdata_o <= start_time_q;
                `AWGSEL_A_STATE: avs_readdata_o <= {29'h0, st_code};
                `AWGSEL_A_TBASE: avs_readdata_o <= 32'(`AWGSEL_STEP_NS);
                `AWGSEL_A_COUNT: avs_readdata_o <= {21'h0, count_q};
                `AWGSEL_A_RDIDX: avs_readdata_o <= {22'h0, rdidx_q};
                `AWGSEL_A_RDVAL: avs_readdata_o <=
                    (rdidx_q < count_q) ? rd_word[31:0] : 32'h0000_0000;
                `AWGSEL_A_RDTS: avs_readdata_o <=
                    (rdidx_q < count_q) ? rd_word[63:32] : 32'h0000_0000;
                // parts per 65536 of instruction capacity
                `AWGSEL_A_PSIZE: avs_readdata_o <=
                    32'((prog_len_i * 65536) / `AWGSEL_IMEM);
                `AWGSEL_A_PC: avs_readdata_o <=
                    {17'h0, program_counter_i};
                `AWGSEL_A_SFLAGS: begin
                    avs_readdata_o <= 32'h0000_0000;
                    avs_readdata_o[`AWGSEL_ST_RUN] <= seq_running_i;
                    avs_readdata_o[`AWGSEL_ST_TWAIT] <= seq_wait_trig_i;
                    avs_readdata_o[`AWGSEL_ST_ERR] <= seq_error_i;
                    avs_readdata_o[`AWGSEL_ST_SYNC] <= seq_wait_sync_i;
                end
                `AWGSEL_A_TRIGD: avs_readdata_o <= {31'h0, trig_seen_q};
                `AWGSEL_A_SINGLE: avs_readdata_o <= {31'h0, one_shot_q};
                `AWGSEL_A_RATE: avs_readdata_o <= {28'h0, rate_q};
                `AWGSEL_A_WMEM: avs_readdata_o <=
                    32'((wave_len_i * 100) / `AWGSEL_WMEM);
                `AWGSEL_A_PLAY: avs_readdata_o <= {31'h0, wave_playing_i};
                `AWGSEL_A_BUSY: avs_readdata_o <= {31'h0, settling_i};
                `AWGSEL_A_INTERNAL: avs_readdata_o <= {31'h0, no_upconv_i};
                `AWGSEL_A_MARKER: avs_readdata_o <= {27'h0, mk_sel_q};
                `AWGSEL_A_USER0: avs_readdata_o <= ureg_q[0];
                8'h64: avs_readdata_o <= ureg_q[1];
                8'h68: avs_readdata_o <= ureg_q[2];
                8'h6C: avs_readdata_o <= ureg_q[3];
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            marker_o <= 1'b0;
        end else if (mk_sel_q < 5'd4) begin
            marker_o <= sequencer_trigger_line_i[mk_sel_q[1:0]];
        end else if (mk_sel_q < 5'd8) begin
            marker_o <= waveform_marker_bit_i[mk_sel_q[1:0]];
        end else if (mk_sel_q < `AWGSEL_MK_LOW) begin
            marker_o <= trigger_input_line_i[mk_sel_q[2:0]];
        end else begin
            marker_o <= (mk_sel_q == `AWGSEL_MK_HIGH);
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            one_shot_o <= 1'b0;
            rate_div_o <= 4'h0;
        end else begin
            one_shot_o <= one_shot_q;
            rate_div_o <= rate_q;
        end
    end
endmodule

// ==== sim/awgsel_sva.sv ====
// port-level assertions for the sequencer control block
`timescale 1ns/10ps
`include "awgsel_defs.svh"
module awgsel_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // bus
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // status and user port
    input wire logic seq_running_i,
    input wire logic seq_wait_trig_i,
    input wire logic seq_error_i,
    input wire logic seq_wait_sync_i,
    input wire logic wave_playing_i,
    input wire logic seq_ureg_we_i,
    input wire logic [1:0] seq_ureg_idx_i,
    input wire logic [31:0] seq_ureg_wdata_i,
    input wire logic [31:0] seq_ureg_rdata_o,
    // settings out
    input wire logic one_shot_o,
    input wire logic [3:0] rate_div_o,
    input wire logic marker_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_bus_answer: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered next cycle");
    chk_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    chk_rate_clamp: assert property (rate_div_o <= 4'hd)
        else $error("rate divider above limit");
    chk_ureg_follow: assert property (seq_ureg_we_i ##1
        (!seq_ureg_we_i && !avs_write_i && $stable(seq_ureg_idx_i)) |=>
        seq_ureg_rdata_o == $past(seq_ureg_wdata_i, 2))
        else $error("sequencer write not read back");
    chk_status_bits: assert property (avs_read_i && avs_waitrequest_o &&
        avs_address_i == `AWGSEL_A_SFLAGS |=> avs_readdata_o == {27'h0,
        $past(seq_wait_sync_i), $past(seq_error_i), $past(seq_wait_trig_i),
        1'b0, $past(seq_running_i)})
        else $error("status word wrong");
    chk_play_read: assert property (avs_read_i && avs_waitrequest_o &&
        avs_address_i == `AWGSEL_A_PLAY |=>
        avs_readdata_o == {31'h0, $past(wave_playing_i)})
        else $error("playing flag wrong");
    chk_tbase_read: assert property (avs_read_i && avs_waitrequest_o &&
        avs_address_i == `AWGSEL_A_TBASE |=> avs_readdata_o == 32'h0000_0004)
        else $error("timebase wrong");
    chk_reset_outputs: assert property (disable iff (1'b0) !rst_b_i |=>
        avs_waitrequest_o && !one_shot_o && !marker_o && rate_div_o == 4'h0)
        else $error("outputs not reset");
endmodule

// ==== sim/awgsel_ctrl_model.sv ====
// external controller model driving the two event sources
`timescale 1ns/10ps
module awgsel_ctrl_model (
    // clock
    input wire logic clk_i,
    // event outputs
    output logic [31:0] dio_data_o,
    output logic dio_valid_o,
    output logic [31:0] link_data_o,
    output logic link_valid_o
);
    initial begin
        {dio_data_o, dio_valid_o, link_data_o, link_valid_o} = '0;
    end
    // data settles a cycle ahead of valid so no bit moves as the strobe rises
    task automatic send(input logic s, input logic [31:0] d, input int gap);
        @(posedge clk_i);
        if (s) link_data_o <= d; else dio_data_o <= d;
        @(posedge clk_i);
        if (s) link_valid_o <= 1'b1; else dio_valid_o <= 1'b1;
        @(posedge clk_i);
        link_valid_o <= 1'b0;
        dio_valid_o <= 1'b0;
        // released data is scrambled, never left at the last value
        if (s) link_data_o <= ~d; else dio_data_o <= ~d;
        repeat (gap + 1) @(posedge clk_i);
    endtask
endmodule

// ==== sim/awgsel_top_tb_top.sv ====
// self-checking bench for the sequencer control and event logger
`timescale 1ns/10ps
`include "awgsel_defs.svh"
module awgsel_top_tb_top;
    logic clk_i = 1'b0;
    logic rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o, dio_valid_i;
    logic link_valid_i, seq_running_i, seq_wait_trig_i, seq_error_i;
    logic seq_wait_sync_i, seq_trigger_i, wave_playing_i, settling_i;
    logic no_upconv_i, seq_ureg_we_i, one_shot_o, marker_o;
    logic [7:0] avs_address_i, trigger_input_line_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, dio_data_i, link_data_i;
    logic [31:0] seq_ureg_wdata_i, seq_ureg_rdata_o;
    logic [14:0] program_counter_i;
    logic [15:0] prog_len_i;
    logic [16:0] wave_len_i;
    logic [3:0] sequencer_trigger_line_i, waveform_marker_bit_i, rate_div_o;
    logic [1:0] seq_ureg_idx_i;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #12.5 clk_i = ~clk_i;
    awgsel_top awgsel_top_i (.*);
    awgsel_ctrl_model awgsel_ctrl_model_i (.clk_i(clk_i),
        .dio_data_o(dio_data_i), .dio_valid_o(dio_valid_i),
        .link_data_o(link_data_i), .link_valid_o(link_valid_i));
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // entered just after an edge; holds the request until waitrequest is low
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (n >= 50) begin
            chk("bus timeout", 32'h0, 32'h1);
            results();
        end
        @(posedge clk_i);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
        logic [31:0] q;
        rd(a, q);
        chk(nm, e, q);
    endtask
    task automatic t_regs();
        program_counter_i <= 15'h1234;
        prog_len_i <= 16'h4000;
        wave_len_i <= 17'h0_c000;
        {seq_wait_trig_i, seq_error_i, wave_playing_i, settling_i} <= 4'hf;
        rdc("tbase", `AWGSEL_A_TBASE, 32'h0000_0004);
        rdc("psize", `AWGSEL_A_PSIZE, 32'h0000_8000);
        rdc("pc", `AWGSEL_A_PC, 32'h0000_1234);
        rdc("flags", `AWGSEL_A_SFLAGS, 32'h0000_000c);
        rdc("play", `AWGSEL_A_PLAY, 32'h0000_0001);
        rdc("wmem", `AWGSEL_A_WMEM, 32'h0000_0032);
        rdc("busy", `AWGSEL_A_BUSY, 32'h0000_0001);
        rdc("internal", `AWGSEL_A_INTERNAL, 32'h0000_0000);
        rdc("unmapped", 8'hfc, 32'h0000_0000);
        wr(`AWGSEL_A_RATE, 32'h0000_000e);
        wr(`AWGSEL_A_SINGLE, 32'h0000_0001);
        @(posedge clk_i);
        chk("rate pin", 32'h0000_000d, {28'h0, rate_div_o});
        chk("single", 32'h0000_0001, {31'h0, one_shot_o});
        rdc("rate", `AWGSEL_A_RATE, 32'h0000_000d);
        seq_ureg_idx_i <= 2'h1;
        wr(`AWGSEL_A_USER0 + 8'h04, 32'h1111_2222);
        rdc("user1", `AWGSEL_A_USER0 + 8'h04, 32'h1111_2222);
        chk("seq read", 32'h1111_2222, seq_ureg_rdata_o);
        {seq_ureg_we_i, seq_ureg_idx_i} <= 3'h6;
        seq_ureg_wdata_i <= 32'h3333_4444;
        @(posedge clk_i);
        seq_ureg_we_i <= 1'b0;
        rdc("user2", `AWGSEL_A_USER0 + 8'h08, 32'h3333_4444);
        $display("done regs");
    endtask
    task automatic t_marker();
        logic e;
        for (int v = 0; v < 2; v++) begin
            for (int c = 0; c < 19; c++) begin
                {trigger_input_line_i, waveform_marker_bit_i,
                    sequencer_trigger_line_i} <= 16'(v ? ~(1 << c) : 1 << c);
                // code 18 is refused, so the level of code 17 stays
                e = (c >= 17) || (c < 16 && v == 0);
                wr(`AWGSEL_A_MARKER, 32'(c));
                @(posedge clk_i);
                chk("marker", {31'h0, e}, {31'h0, marker_o});
            end
        end
        $display("done marker");
    endtask
    task automatic t_normal();
        logic [31:0] q0, q1;
        wr(`AWGSEL_A_ENABLE, 32'h1);
        wr(`AWGSEL_A_CLEAR, 32'h1);
        awgsel_ctrl_model_i.send(1'b0, 32'h5555_aaaa, 0);
        rdc("idle cnt", `AWGSEL_A_COUNT, 32'h0);
        rdc("idle st", `AWGSEL_A_STATE, 32'h0);
        seq_running_i <= 1'b1;
        @(posedge clk_i);
        rdc("run st", `AWGSEL_A_STATE, 32'h1);
        for (int k = 0; k < 1027; k++) begin
            awgsel_ctrl_model_i.send(1'b0, 32'(k), 0);
            if (k == 2) begin
                awgsel_ctrl_model_i.send(1'b1, 32'hdead_beef, 0);
                rdc("cnt", `AWGSEL_A_COUNT, 32'h3);
                wr(`AWGSEL_A_RDIDX, 32'h1);
                rd(`AWGSEL_A_RDTS, q1);
                wr(`AWGSEL_A_RDIDX, 32'h0);
                rd(`AWGSEL_A_RDTS, q0);
                rdc("data0", `AWGSEL_A_RDVAL, 32'h0);
                chk("ts step", 32'h4, q1 - q0);
            end
        end
        rdc("wrap cnt", `AWGSEL_A_COUNT, 32'h0000_0400);
        wr(`AWGSEL_A_RDIDX, 32'h0);
        rdc("wrap data", `AWGSEL_A_RDVAL, 32'h0000_0400);
        $display("done normal");
    endtask
    task automatic t_timed();
        logic [31:0] q;
        int n;
        seq_running_i <= 1'b0;
        wr(`AWGSEL_A_MODE, 32'h1);
        wr(`AWGSEL_A_INSEL, 32'h1);
        wr(`AWGSEL_A_START, 32'h0000_0100);
        wr(`AWGSEL_A_CLEAR, 32'h1);
        seq_running_i <= 1'b1;
        @(posedge clk_i);
        rdc("wait st", `AWGSEL_A_STATE, 32'h2);
        rdc("no trig", `AWGSEL_A_TRIGD, 32'h0);
        awgsel_ctrl_model_i.send(1'b1, 32'h0bad_0001, 0);
        rdc("pre cnt", `AWGSEL_A_COUNT, 32'h0);
        seq_trigger_i <= 1'b1;
        @(posedge clk_i);
        seq_trigger_i <= 1'b0;
        rdc("trig", `AWGSEL_A_TRIGD, 32'h1);
        rdc("still wait", `AWGSEL_A_STATE, 32'h2);
        n = 0;
        do begin
            rd(`AWGSEL_A_STATE, q);
            n++;
        end while (q !== 32'h3 && n < 200);
        chk("rec st", 32'h3, q);
        for (int k = 0; k < 1026; k++)
            awgsel_ctrl_model_i.send(1'b1, 32'(k), 0);
        rdc("full cnt", `AWGSEL_A_COUNT, 32'h0000_0400);
        rdc("full st", `AWGSEL_A_STATE, 32'h4);
        wr(`AWGSEL_A_RDIDX, 32'h0);
        rdc("first", `AWGSEL_A_RDVAL, 32'h0);
        rd(`AWGSEL_A_RDTS, q);
        chk("start ts", 32'h1, {31'h0, q >= 32'h0000_0100});
        wr(`AWGSEL_A_CLEAR, 32'h1);
        rdc("clr cnt", `AWGSEL_A_COUNT, 32'h0);
        rdc("clr data", `AWGSEL_A_RDVAL, 32'h0);
        wr(`AWGSEL_A_ENABLE, 32'h0);
        rdc("off st", `AWGSEL_A_STATE, 32'h0);
        awgsel_ctrl_model_i.send(1'b1, 32'h1234_5678, 0);
        rdc("off cnt", `AWGSEL_A_COUNT, 32'h0);
        $display("done timed");
    endtask
    initial begin
        {rst_b_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i,
            seq_running_i, seq_wait_trig_i, seq_error_i, seq_wait_sync_i,
            seq_trigger_i, program_counter_i, prog_len_i, wave_len_i,
            wave_playing_i, settling_i, no_upconv_i, seq_ureg_we_i,
            seq_ureg_idx_i, seq_ureg_wdata_i, trigger_input_line_i,
            waveform_marker_bit_i, sequencer_trigger_line_i} = '0;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_marker();
        t_normal();
        t_timed();
        results();
    end
endmodule
bind awgsel_top awgsel_sva awgsel_sva_i (.*);
